// *** bench/epi_pins.sv ***
// partner model driving the external request pin and the pin-change pins
`timescale 1ns/100ps
module epi_pins (
  input  wire logic        aclk,
  input  wire logic        ext_cmd,
  input  wire logic [15:0] pc_cmd,
  output logic             ext_request_pin,
  output logic [15:0]      pin_change_inputs
);
  // ****************
  // pin drivers
  // ****************
  // request pin idles high and pin-change pins idle low until commanded
  initial begin
    ext_request_pin = 1'b1;
    pin_change_inputs = 16'h0000;
  end
  // levels move just after an edge and hold many periods, so low levels outlast an instruction
  always @(posedge aclk) begin
    ext_request_pin <= ext_cmd;
    pin_change_inputs <= pc_cmd;
  end
endmodule

// *** bench/epi_unit_test.sv ***
// self-checking bench of the pin interrupt unit
`timescale 1ns/100ps
module epi_unit_test;
  localparam logic [15:0] BOOT = 16'h1C00; // arbitrary boot base word
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [11:0]        awaddr = 12'h000;
  logic [11:0]        araddr = 12'h000;
  logic [31:0]        wdata = 32'h0000_0000;
  logic [3:0]         wstrb = 4'hF;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               arvalid = 1'b0;
  logic               bready = 1'b1;
  logic               rready = 1'b1;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, resp;
  logic [31:0]        rdata, rdv;
  logic               ext_cmd = 1'b1;
  logic [15:0]        pc = 16'h0000;
  logic               ext_pin, nv, ev, eh, el;
  logic [15:0]        pins_q, vbase, flip;
  logic [7:0]         mh, ml, en;
  logic [31:0]        tmp;
  epi_pkg::epi_irq_t  irq;
  epi_pkg::epi_wake_t wake;
  int                 n_mismatch = 0;
  int                 checks = 0;
  int                 seed, m, k;
  int                 n_wake = 0;
  int                 w0;

  // count pin-change wake pulses, one per cycle with any enabled masked toggle in either group
  always @(posedge aclk) begin
    if (wake.pin_change_wake === 1'b1) n_wake++;
  end

  // clock
  always #4 aclk = ~aclk;

  // design and pin partner
  epi_unit #(.BOOT_BASE_WORD(BOOT)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_request_pin(ext_pin), .pin_change_inputs(pins_q), .irq_q(irq), .wake_q(wake),
    .vector_base_q(vbase));
  epi_pins pins_m (.aclk(aclk), .ext_cmd(ext_cmd), .pc_cmd(pc),
    .ext_request_pin(ext_pin), .pin_change_inputs(pins_q));

  // ****************
  // helpers
  // ****************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    n_mismatch++;
    $display("no answer on %s", what);
    end_sim();
  endtask
  // write one byte; both responses are always accepted
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int i;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 64) hang("write");
    resp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 64) hang("read");
    rdv = rdata;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk("register", rdv, {24'h0, e});
  endtask
  // pins move, then settle through sync, flag and request stages
  task automatic pins(input logic e, input logic [15:0] p);
    ext_cmd <= e;
    pc <= p;
    repeat (7) @(posedge aclk);
  endtask
  function automatic logic exp_edge(input logic [1:0] md, input logic o, input logic n);
    case (md)
      epi_pkg::SENSE_ANY:  return o ^ n;
      epi_pkg::SENSE_FALL: return o & ~n;
      epi_pkg::SENSE_RISE: return ~o & n;
      default:             return 1'b0;
    endcase
  endfunction

  // ****************
  // main sequence
  // ****************
  initial begin
    seed = 32'h2FC2;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(epi_pkg::ADDR_SENSE_CTRL, 8'h00);
    rc(epi_pkg::ADDR_ENABLE_MASK, 8'h00);
    rc(epi_pkg::ADDR_REQ_FLAGS, 8'h00);
    rc(epi_pkg::ADDR_VEC_CTRL, 8'h00);
    chk("vector base", vbase, 32'h0);
    wr(epi_pkg::ADDR_SENSE_CTRL, 8'hFF);
    rc(epi_pkg::ADDR_SENSE_CTRL, 8'h03);
    wstrb <= 4'h0;
    wr(epi_pkg::ADDR_SENSE_CTRL, 8'h00);
    wstrb <= 4'hF;
    rc(epi_pkg::ADDR_SENSE_CTRL, 8'h03);
    wr(12'hFFC, 8'hFF);
    chk("bresp", resp, epi_pkg::RESP_SLVERR);
    rc(12'hFFC, 8'h00);
    $display("test registers done");
    // every sense code against random pin moves
    wr(epi_pkg::ADDR_CORE_CTRL, 8'h01);
    wr(epi_pkg::ADDR_ENABLE_MASK, 8'hC1);
    for (m = 0; m < 4; m++) begin
      wr(epi_pkg::ADDR_SENSE_CTRL, 8'(m));
      pins(1'b1, pc);
      wr(epi_pkg::ADDR_REQ_FLAGS, 8'h01);
      for (k = 0; k < 6; k++) begin
        tmp = $random(seed);
        nv = (k == 0) ? 1'b0 : tmp[0];
        ev = exp_edge(2'(m), ext_cmd, nv);
        pins(nv, pc);
        chk("ext irq", irq.ext_request, (m == 0) ? !nv : ev);
        chk("level wake", wake.low_level_wake, (m == 0) && !nv);
        rc(epi_pkg::ADDR_REQ_FLAGS, {7'h0, ev});
        if (k[0]) wr(epi_pkg::ADDR_CORE_CTRL, 8'h11);
        else wr(epi_pkg::ADDR_REQ_FLAGS, 8'h01);
        rc(epi_pkg::ADDR_REQ_FLAGS, 8'h00);
      end
    end
    pins(1'b1, pc);
    $display("test sense modes done");
    // random masks and toggles on both groups
    for (k = 0; k < 8; k++) begin
      tmp = $random(seed);
      mh = tmp[7:0];
      ml = tmp[15:8];
      flip = (k == 1) ? 16'hFFFF : tmp[31:16];
      en = k[0] ? 8'hC0 : 8'h00;
      wr(epi_pkg::ADDR_PC_HIGH_MASK, mh);
      wr(epi_pkg::ADDR_PC_LOW_MASK, ml);
      wr(epi_pkg::ADDR_ENABLE_MASK, en);
      wr(epi_pkg::ADDR_REQ_FLAGS, 8'hC1);
      eh = en[7] & |(flip[15:8] & mh);
      el = en[6] & |(flip[7:0] & ml);
      w0 = n_wake;
      pins(1'b1, pc ^ flip);
      chk("pin wake", n_wake - w0, eh | el);
      rc(epi_pkg::ADDR_REQ_FLAGS, {eh, el, 6'h0});
      chk("group irq", {irq[2], irq[1]}, {eh, el});
    end
    $display("test pin change done");
    // vector move with a pending low group request
    wr(epi_pkg::ADDR_ENABLE_MASK, 8'h40);
    wr(epi_pkg::ADDR_PC_LOW_MASK, 8'hFF);
    pins(1'b1, pc ^ 16'h0001);
    chk("low irq", irq.pin_change_group_low_request, 1'b1);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h01);
    chk("blocked", irq.pin_change_group_low_request, 1'b0);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h02);
    rc(epi_pkg::ADDR_VEC_CTRL, 8'h02);
    chk("vector base", vbase, BOOT);
    chk("blocked", irq.pin_change_group_low_request, 1'b0);
    wr(epi_pkg::ADDR_CORE_CTRL, 8'h81);
    rc(epi_pkg::ADDR_CORE_CTRL, 8'h01);
    chk("released", irq.pin_change_group_low_request, 1'b1);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h01);
    repeat (8) @(posedge aclk);
    rc(epi_pkg::ADDR_VEC_CTRL, 8'h02);
    chk("released", irq.pin_change_group_low_request, 1'b1);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h00);
    chk("vector base", vbase, BOOT);
    wr(epi_pkg::ADDR_CORE_CTRL, 8'h07);
    @(posedge aclk);
    chk("lock block", irq.pin_change_group_low_request, 1'b0);
    wr(epi_pkg::ADDR_CORE_CTRL, 8'h05);
    @(posedge aclk);
    chk("lock free", irq.pin_change_group_low_request, 1'b1);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h01);
    wr(epi_pkg::ADDR_VEC_CTRL, 8'h00);
    @(posedge aclk);
    chk("vector base", vbase, 32'h0);
    wr(epi_pkg::ADDR_CORE_CTRL, 8'h89);
    @(posedge aclk);
    chk("lock block", irq.pin_change_group_low_request, 1'b0);
    $display("test vector move done");
    end_sim();
  end
endmodule

// *** hw/epi_unit.sv ***
// external pin and pin-change interrupt unit with vector placement control
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module epi_unit #(
  parameter logic [15:0] BOOT_BASE_WORD = 16'h1C00
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 ext_request_pin,
  input  wire logic [15:0]          pin_change_inputs,
  output epi_pkg::epi_irq_t         irq_q,
  output epi_pkg::epi_wake_t        wake_q,
  output logic [15:0]               vector_base_q
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [16:0] sync1_q;
  logic [16:0] sync2_q;
  logic        ext_prev_q;
  logic [15:0] pc_prev_q;

  // two stages, only the second is read by logic
  always_ff @(posedge aclk) begin
    sync1_q <= {ext_request_pin, pin_change_inputs};
    sync2_q <= sync1_q;
  end

  wire       ext_now = sync2_q[16];
  wire [15:0] pc_now = sync2_q[15:0];

  // previous sample for edge compare
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_q <= 1'b1;
      pc_prev_q  <= 16'h0000;
    end else begin
      ext_prev_q <= ext_now;
      pc_prev_q  <= pc_now;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [1:0] sense_q;
  logic [7:0] pc_high_mask_q;
  logic [7:0] pc_low_mask_q;
  logic       vec_sel_q;
  logic       unlock_q;
  logic [2:0] unlock_cnt_q;
  logic       hold_q;
  logic [7:0] enable_q;
  logic [7:0] flags_q;
  logic [7:0] core_q;

  // ************************************************************
  // bus decode
  // ************************************************************
  logic        aw_got_q;
  logic        w_got_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_got_q && w_got_q && !s_axi_bvalid;
  wire wr_lane = w_strb_q[0];

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a[11:2] == r[11:2]);
  endfunction

  wire wr_sense = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_SENSE_CTRL);
  wire wr_pch   = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_PC_HIGH_MASK);
  wire wr_pcl   = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_PC_LOW_MASK);
  wire wr_vec   = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_VEC_CTRL);
  wire wr_en    = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_ENABLE_MASK);
  wire wr_flag  = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_REQ_FLAGS);
  wire wr_core  = wr_go && wr_lane && hit(aw_addr_q, epi_pkg::ADDR_CORE_CTRL);
  wire wr_known = hit(aw_addr_q, epi_pkg::ADDR_SENSE_CTRL)
                | hit(aw_addr_q, epi_pkg::ADDR_PC_HIGH_MASK)
                | hit(aw_addr_q, epi_pkg::ADDR_PC_LOW_MASK)
                | hit(aw_addr_q, epi_pkg::ADDR_VEC_CTRL)
                | hit(aw_addr_q, epi_pkg::ADDR_ENABLE_MASK)
                | hit(aw_addr_q, epi_pkg::ADDR_REQ_FLAGS)
                | hit(aw_addr_q, epi_pkg::ADDR_CORE_CTRL)
                | hit(aw_addr_q, epi_pkg::ADDR_STATUS);
  wire [7:0] wbyte = w_data_q[7:0];

  // write channel capture, response after both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= epi_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_q && !aw_take;
      s_axi_wready  <= !w_got_q && !w_take;
      if (aw_take) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // vector placement and change window
  // ************************************************************
  wire ack_ext   = wr_core && wbyte[epi_pkg::ACK_EXT_BIT];
  wire ack_low   = wr_core && wbyte[epi_pkg::ACK_LOW_BIT];
  wire ack_high  = wr_core && wbyte[epi_pkg::ACK_HIGH_BIT];
  wire insn_done = wr_core && wbyte[epi_pkg::INSN_DONE_BIT];
  wire set_unlk  = wr_vec && wbyte[epi_pkg::VEC_UNLK_BIT] && !unlock_q;
  wire sel_write = wr_vec && unlock_q && !wbyte[epi_pkg::VEC_UNLK_BIT];
  wire unlk_end  = unlock_q && (unlock_cnt_q == epi_pkg::UNLOCK_CYCLES - 3'h1);

  // unlock self clears after four cycles or at select write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_sel_q    <= 1'b0;
      unlock_q     <= 1'b0;
      unlock_cnt_q <= 3'h0;
      hold_q       <= 1'b0;
    end else begin
      if (set_unlk) begin
        unlock_q     <= 1'b1;
        unlock_cnt_q <= 3'h0;
      end else if (sel_write) begin
        unlock_q  <= 1'b0;
        vec_sel_q <= wbyte[epi_pkg::VEC_SEL_BIT];
        hold_q    <= 1'b1;
      end else if (unlk_end) begin
        unlock_q <= 1'b0;
      end else if (unlock_q) begin
        unlock_cnt_q <= unlock_cnt_q + 3'h1;
      end
      if (hold_q && insn_done) begin
        hold_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // detection and flags
  // ************************************************************
  wire is_low   = (sense_q == epi_pkg::SENSE_LOW);
  wire ext_rise = ext_now && !ext_prev_q;
  wire ext_fall = !ext_now && ext_prev_q;
  wire ext_trig = (sense_q == epi_pkg::SENSE_ANY  && (ext_rise || ext_fall))
                | (sense_q == epi_pkg::SENSE_FALL && ext_fall)
                | (sense_q == epi_pkg::SENSE_RISE && ext_rise);
  wire [15:0] pc_tog = pc_now ^ pc_prev_q;
  wire pc_high_hit = enable_q[epi_pkg::PC_HIGH_BIT] && |(pc_tog[15:8] & pc_high_mask_q);
  wire pc_low_hit  = enable_q[epi_pkg::PC_LOW_BIT]  && |(pc_tog[7:0] & pc_low_mask_q);
  wire clr_ext  = ack_ext  || (wr_flag && wbyte[epi_pkg::EXT_BIT]);
  wire clr_low  = ack_low  || (wr_flag && wbyte[epi_pkg::PC_LOW_BIT]);
  wire clr_high = ack_high || (wr_flag && wbyte[epi_pkg::PC_HIGH_BIT]);

  // sticky flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= epi_pkg::RST_BYTE;
    end else begin
      flags_q[epi_pkg::EXT_BIT] <= !is_low && (ext_trig ||
                                   (flags_q[epi_pkg::EXT_BIT] && !clr_ext));
      flags_q[epi_pkg::PC_LOW_BIT] <= pc_low_hit ||
                                      (flags_q[epi_pkg::PC_LOW_BIT] && !clr_low);
      flags_q[epi_pkg::PC_HIGH_BIT] <= pc_high_hit ||
                                       (flags_q[epi_pkg::PC_HIGH_BIT] && !clr_high);
    end
  end

  // plain control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_q        <= epi_pkg::SENSE_LOW;
      pc_high_mask_q <= epi_pkg::RST_BYTE;
      pc_low_mask_q  <= epi_pkg::RST_BYTE;
      enable_q       <= epi_pkg::RST_BYTE;
      core_q         <= epi_pkg::RST_BYTE;
    end else begin
      if (wr_sense) sense_q <= wbyte[1:0];
      if (wr_pch)   pc_high_mask_q <= wbyte;
      if (wr_pcl)   pc_low_mask_q <= wbyte;
      if (wr_en) begin
        enable_q <= wbyte & 8'hC1;
      end
      if (wr_core) begin
        core_q <= wbyte & 8'h0F;
      end
    end
  end

  // ************************************************************
  // request gating toward the core
  // ************************************************************
  wire gie       = core_q[epi_pkg::GIE_BIT];  // global enable, never written by blocking
  wire app_exec  = core_q[epi_pkg::APP_EXEC_BIT];
  wire lock_off  = (vec_sel_q && core_q[epi_pkg::APP_LOCK_BIT] && app_exec)
                 | (!vec_sel_q && core_q[epi_pkg::BOOT_LOCK_BIT] && !app_exec);
  // a fresh unlock write blocks at once, so no request leaks out in the cycle it lands
  wire blocked   = unlock_q || set_unlk || hold_q || lock_off;
  wire allow     = gie && !blocked;
  wire ext_level = is_low && !ext_now;  // not latched: a level that ends early asks nothing
  wire ext_pend  = ext_level || flags_q[epi_pkg::EXT_BIT];

  // registered requests, wake-ups and vector base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q         <= '0;
      wake_q        <= '0;
      vector_base_q <= 16'h0000;
    end else begin
      irq_q.ext_request <= allow && enable_q[epi_pkg::EXT_BIT] && ext_pend;
      irq_q.pin_change_group_low_request <= allow && enable_q[epi_pkg::PC_LOW_BIT]
                                            && flags_q[epi_pkg::PC_LOW_BIT];
      irq_q.pin_change_group_high_request <= allow && enable_q[epi_pkg::PC_HIGH_BIT]
                                             && flags_q[epi_pkg::PC_HIGH_BIT];
      wake_q.pin_change_wake <= pc_high_hit || pc_low_hit;
      wake_q.low_level_wake  <= enable_q[epi_pkg::EXT_BIT] && ext_level;
      vector_base_q <= vec_sel_q ? BOOT_BASE_WORD : 16'h0000;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  wire [11:0] ra = s_axi_araddr;
  wire [7:0] rd_byte =
      hit(ra, epi_pkg::ADDR_SENSE_CTRL)   ? {6'h00, sense_q} :
      hit(ra, epi_pkg::ADDR_PC_HIGH_MASK) ? pc_high_mask_q :
      hit(ra, epi_pkg::ADDR_PC_LOW_MASK)  ? pc_low_mask_q :
      hit(ra, epi_pkg::ADDR_VEC_CTRL)     ? {6'h00, vec_sel_q, unlock_q} :
      hit(ra, epi_pkg::ADDR_ENABLE_MASK)  ? enable_q :
      hit(ra, epi_pkg::ADDR_REQ_FLAGS)    ? flags_q :
      hit(ra, epi_pkg::ADDR_CORE_CTRL)    ? core_q :
      hit(ra, epi_pkg::ADDR_STATUS)       ? {5'h00, hold_q, blocked, ext_now} : 8'h00;
  wire rd_known = hit(ra, epi_pkg::ADDR_SENSE_CTRL) | hit(ra, epi_pkg::ADDR_PC_HIGH_MASK)
                | hit(ra, epi_pkg::ADDR_PC_LOW_MASK) | hit(ra, epi_pkg::ADDR_VEC_CTRL)
                | hit(ra, epi_pkg::ADDR_ENABLE_MASK) | hit(ra, epi_pkg::ADDR_REQ_FLAGS)
                | hit(ra, epi_pkg::ADDR_CORE_CTRL) | hit(ra, epi_pkg::ADDR_STATUS);
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // one read at a time, data one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= epi_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_known ? epi_pkg::RESP_OKAY : epi_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [3:0] unlk_age_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) unlk_age_q <= 4'h0;
    else unlk_age_q <= unlock_q ? unlk_age_q + 4'h1 : 4'h0;
  end

  a_unlock_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
    unlk_age_q <= 4'h4) else $error("unlock held too long");
  a_unlock_release: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(unlock_q) ##0 (!sel_write) [*4] |=> !unlock_q) else $error("unlock not released");
  a_block_unlock: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_unlk || unlock_q) |=> !irq_q.ext_request && !irq_q.pin_change_group_low_request
      && !irq_q.pin_change_group_high_request)
    else $error("request while unlocked");
  a_flag_low_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    is_low |=> !flags_q[epi_pkg::EXT_BIT]) else $error("flag set in low mode");
  a_level_request: assert property (@(posedge aclk) disable iff (!aresetn)
    is_low && !ext_now && allow && enable_q[epi_pkg::EXT_BIT] |=> irq_q.ext_request)
    else $error("level request missing");
  a_gie_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !gie |=> !irq_q.ext_request) else $error("request without global enable");
  a_rise_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    sense_q == epi_pkg::SENSE_RISE && ext_rise |=> flags_q[epi_pkg::EXT_BIT])
    else $error("rising edge missed");
  a_group_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    pc_high_hit |=> flags_q[epi_pkg::PC_HIGH_BIT]) else $error("group flag missed");
  a_sel_write: assert property (@(posedge aclk) disable iff (!aresetn)
    sel_write |=> vec_sel_q == $past(wbyte[epi_pkg::VEC_SEL_BIT]) && hold_q)
    else $error("select write lost");
  a_mask_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_q[epi_pkg::PC_LOW_BIT] |-> !pc_low_hit) else $error("masked group hit");

endmodule

// *** shared/epi_pkg.sv ***
// package of register offsets, field positions and carrier types for the pin interrupt unit
package epi_pkg;

  // register byte addresses (0x69 not a multiple of four: printed offsets are indices)
  localparam logic [7:0]  IDX_SENSE_CTRL   = 8'h69;
  localparam logic [7:0]  IDX_PC_HIGH_MASK = 8'h6C;
  localparam logic [7:0]  IDX_PC_LOW_MASK  = 8'h6B;
  localparam logic [7:0]  IDX_VEC_CTRL     = 8'h55;
  localparam logic [7:0]  IDX_ENABLE_MASK  = 8'h3D;
  localparam logic [7:0]  IDX_REQ_FLAGS    = 8'h3C;
  localparam logic [7:0]  IDX_CORE_CTRL    = 8'h70;
  localparam logic [7:0]  IDX_STATUS       = 8'h71;
  localparam logic [11:0] ADDR_SENSE_CTRL   = {2'h0, IDX_SENSE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_PC_HIGH_MASK = {2'h0, IDX_PC_HIGH_MASK, 2'h0};
  localparam logic [11:0] ADDR_PC_LOW_MASK  = {2'h0, IDX_PC_LOW_MASK, 2'h0};
  localparam logic [11:0] ADDR_VEC_CTRL     = {2'h0, IDX_VEC_CTRL, 2'h0};
  localparam logic [11:0] ADDR_ENABLE_MASK  = {2'h0, IDX_ENABLE_MASK, 2'h0};
  localparam logic [11:0] ADDR_REQ_FLAGS    = {2'h0, IDX_REQ_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_CORE_CTRL    = {2'h0, IDX_CORE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STATUS       = {2'h0, IDX_STATUS, 2'h0};

  // field positions
  localparam int VEC_SEL_BIT   = 1;
  localparam int VEC_UNLK_BIT  = 0;
  localparam int PC_HIGH_BIT   = 7;
  localparam int PC_LOW_BIT    = 6;
  localparam int EXT_BIT       = 0;
  localparam int GIE_BIT       = 0;
  localparam int APP_EXEC_BIT  = 1;
  localparam int APP_LOCK_BIT  = 2;
  localparam int BOOT_LOCK_BIT = 3;
  localparam int ACK_EXT_BIT   = 4;
  localparam int ACK_LOW_BIT   = 5;
  localparam int ACK_HIGH_BIT  = 6;
  localparam int INSN_DONE_BIT = 7;

  // reset values and timing
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // sense modes of the external request pin
  localparam logic [1:0] SENSE_LOW     = 2'h0;
  localparam logic [1:0] SENSE_ANY     = 2'h1;
  localparam logic [1:0] SENSE_FALL    = 2'h2;
  localparam logic [1:0] SENSE_RISE    = 2'h3;

  // interrupt requests toward the core
  typedef struct packed {
    logic pin_change_group_high_request;
    logic pin_change_group_low_request;
    logic ext_request;
  } epi_irq_t;

  // registered wake-up indications
  typedef struct packed {
    logic pin_change_wake;
    logic low_level_wake;
  } epi_wake_t;

endpackage
